// ==== verilog/timer_one.sv ====
// 16-bit timer/counter with prescaler, pin synchroniser and byte registers
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "timer_one_defs.svh"

module timer_one (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire timer_one_pkg::bus_req_t bus_req,
  output logic [7:0] rd_data_r,
  // Pins and core status
  input wire logic ext_count_clock_pin,
  input wire logic osc_input_pin,
  input wire logic [1:0] port_direction,
  input wire logic sleep,
  // Compare unit
  input wire logic compare_reset,
  output logic [15:0] count_out_r,
  output logic timebase_ok_r,
  // Outputs to the core and pads
  output logic irq_r,
  output logic wake_r,
  output logic osc_amp_en_r,
  output logic [1:0] osc_pin_oe_r
);

  import timer_one_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State

  control_t control_r;
  logic flag_r;
  logic ien_r;
  logic [7:0] count_lo_r;
  logic [7:0] count_hi_r;
  logic [1:0] phase_r;
  logic ext_meta_r;
  logic ext_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic samp_r;
  logic samp_prev_r;
  logic inc_dly_r;
  logic async_prev_r;
  logic lo_pend_r;
  logic hi_pend_r;
  logic [7:0] lo_val_r;
  logic [7:0] hi_val_r;

  //////////////////////////////////////////////////////////////////////////
  // Register decode

  wire wr_ctrl = bus_req.wr && bus_req.addr == `OFF_CONTROL;
  wire wr_flag = bus_req.wr && bus_req.addr == `OFF_FLAG;
  wire wr_ien = bus_req.wr && bus_req.addr == `OFF_ENABLE;
  wire wr_lo = bus_req.wr && bus_req.addr == `OFF_COUNT_LO;
  wire wr_hi = bus_req.wr && bus_req.addr == `OFF_COUNT_HI;

  wire [15:0] count = {count_hi_r, count_lo_r};

  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [7:0] ctl,
                                          input logic fl,
                                          input logic en,
                                          input logic [15:0] cnt);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `OFF_CONTROL: r = ctl & `CTRL_WR_MASK;
      `OFF_FLAG: r = {7'h00, fl};
      `OFF_ENABLE: r = {7'h00, en};
      `OFF_COUNT_LO: r = cnt[7:0];
      `OFF_COUNT_HI: r = cnt[15:8];
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_mux

  wire [7:0] rd_next = bus_req.rd ?
    read_mux(bus_req.addr, control_r, flag_r, ien_r, count) : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire on_bit = control_r.counter_on;
  wire ext_mode = control_r.clock_source_select;
  // Sync bit only matters once the external source is picked
  wire async_mode = ext_mode & control_r.sync_bypass;

  count_mode_t mode;
  assign mode = !ext_mode ? MODE_TIMER :
                async_mode ? MODE_ASYNC_COUNT : MODE_SYNC_COUNT;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end
    else
    begin
      ext_meta_r <= ext_count_clock_pin;
      ext_sync_r <= ext_meta_r;
      osc_meta_r <= osc_input_pin;
      osc_sync_r <= osc_meta_r;
    end
  end

  // Oscillator on moves the count input to the oscillator input pin
  wire pin_lvl = control_r.crystal_osc_enable ? osc_sync_r : ext_sync_r;

  //////////////////////////////////////////////////////////////////////////
  // Four-phase instruction clock

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end

  // Fosc/4 square wave: one rise per instruction cycle
  wire inst_lvl = phase_r[1];
  wire src_lvl = ext_mode ? pin_lvl : inst_lvl;

  //////////////////////////////////////////////////////////////////////////
  // Prescaler

  wire presc_out;
  // The core clock stops in sleep, so the timer-mode source freezes too
  wire presc_in = src_lvl & ~(sleep & ~ext_mode);

  ripple_prescaler #(
    .CNT_W(3)
  ) u_presc (
    .clk(clk),
    .resetn(resetn),
    .clear(wr_lo | wr_hi),
    .sel(control_r.prescale_select),
    .lvl_in(presc_in),
    .lvl_out(presc_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Synchroniser on Q2/Q4 and increment timing

  wire samp_phase = phase_r == `PHASE_Q2 || phase_r == `PHASE_Q4;
  // Sampler is shut off in sleep, prescaler is not
  wire samp_en = samp_phase & ~sleep;
  wire sync_rise = samp_r & ~samp_prev_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      samp_r <= 1'b0;
      samp_prev_r <= 1'b0;
      inc_dly_r <= 1'b0;
      async_prev_r <= 1'b0;
    end
    else
    begin
      if (samp_en)
      begin
        samp_r <= presc_out;
        samp_prev_r <= samp_r;
      end
      // One stage between the sampled edge and the increment
      inc_dly_r <= sync_rise & samp_en;
      async_prev_r <= presc_out;
    end
  end

  // Unsynchronised path ignores phase and sleep entirely
  wire async_tick = presc_out & ~async_prev_r;

  logic tick;
  always_comb
  begin
    tick = 1'b0;
    unique case (mode)
      MODE_TIMER: tick = inc_dly_r;
      MODE_SYNC_COUNT: tick = inc_dly_r;
      MODE_ASYNC_COUNT: tick = async_tick;
      default: tick = 1'b0;
    endcase
  end

  wire inc = tick & on_bit;

  //////////////////////////////////////////////////////////////////////////
  // Count writes wait for the increment boundary

  wire boundary = phase_r == `PHASE_Q4;
  wire apply = boundary & (lo_pend_r | hi_pend_r);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lo_pend_r <= 1'b0;
      hi_pend_r <= 1'b0;
      lo_val_r <= 8'h00;
      hi_val_r <= 8'h00;
    end
    else
    begin
      if (wr_lo)
        lo_val_r <= bus_req.wdata;
      if (wr_hi)
        hi_val_r <= bus_req.wdata;
      // A new write in the apply cycle stays pending
      lo_pend_r <= wr_lo | (lo_pend_r & ~boundary);
      hi_pend_r <= wr_hi | (hi_pend_r & ~boundary);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Count register

  wire [15:0] count_inc = count + 16'h0001;
  wire ovf = inc & (count == `COUNT_MAX);

  logic [7:0] lo_nxt;
  logic [7:0] hi_nxt;
  always_comb
  begin
    lo_nxt = count_lo_r;
    hi_nxt = count_hi_r;
    if (apply)
    begin
      // Write wins over both reset and increment
      lo_nxt = lo_pend_r ? lo_val_r : count_lo_r;
      hi_nxt = hi_pend_r ? hi_val_r : count_hi_r;
    end
    else if (compare_reset)
    begin
      lo_nxt = 8'h00;
      hi_nxt = 8'h00;
    end
    else if (inc)
    begin
      lo_nxt = count_inc[7:0];
      hi_nxt = count_inc[15:8];
    end
  end

  // No reset: the count survives every device reset
  always_ff @(posedge clk)
  begin
    count_lo_r <= lo_nxt;
    count_hi_r <= hi_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Control, flag and enable registers

  // A write or compare reset in the same cycle swallows the overflow
  wire ovf_set = ovf & ~apply & ~compare_reset;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      control_r <= control_t'(`CTRL_RESET);
    else if (wr_ctrl)
      control_r <= control_t'(bus_req.wdata & `CTRL_WR_MASK);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_r <= 1'b0;
      ien_r <= 1'b0;
    end
    else
    begin
      // Set beats a clear in the same cycle
      if (ovf_set)
        flag_r <= 1'b1;
      else if (wr_flag)
        flag_r <= bus_req.wdata[`FLAG_BIT];
      if (wr_ien)
        ien_r <= bus_req.wdata[`IEN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // With the crystal on both pads are forced to inputs
  wire [1:0] oe_nxt = control_r.crystal_osc_enable ? 2'b00 :
                      ~port_direction;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_r <= 8'h00;
      count_out_r <= 16'h0000;
      timebase_ok_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      osc_amp_en_r <= 1'b0;
      osc_pin_oe_r <= 2'b00;
    end
    else
    begin
      rd_data_r <= rd_next;
      count_out_r <= count;
      timebase_ok_r <= ~async_mode;
      irq_r <= flag_r & ien_r;
      wake_r <= flag_r & ien_r & sleep & async_mode;
      osc_amp_en_r <= control_r.crystal_osc_enable;
      osc_pin_oe_r <= oe_nxt;
    end
  end

endmodule : timer_one

// ==== verilog/timer_one_defs.svh ====
// Register offsets, field positions and reset values of the 16-bit timer
`ifndef TIMER_ONE_DEFS_SVH
`define TIMER_ONE_DEFS_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFF_FLAG 8'h0c
`define OFF_COUNT_LO 8'h0e
`define OFF_COUNT_HI 8'h0f
`define OFF_CONTROL 8'h10
`define OFF_ENABLE 8'h8c

`define CTRL_ON_BIT 0
`define CTRL_SRC_BIT 1
`define CTRL_SYNC_BIT 2
`define CTRL_OSC_BIT 3
`define CTRL_PS_LO 4
`define CTRL_PS_HI 5
`define CTRL_WR_MASK 8'h3f

`define CTRL_RESET 8'h00
`define FLAG_BIT 0
`define IEN_BIT 0

`define PHASE_Q2 2'h1
`define PHASE_Q4 2'h3
`define COUNT_MAX 16'hffff

`endif

// ==== verilog/timer_one_pkg.sv ====
// Types shared by the 16-bit timer and its bench
package timer_one_pkg;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_bypass;
    logic clock_source_select;
    logic counter_on;
  } control_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_SYNC_COUNT = 2'b01,
    MODE_ASYNC_COUNT = 2'b10
  } count_mode_t;

endpackage : timer_one_pkg

// ==== verilog/ripple_prescaler.sv ====
// Divide-by-1/2/4/8 prescaler with a symmetric level output
`timescale 1ns/100ps
module ripple_prescaler #(
  parameter int CNT_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic [1:0] sel,
  // Count level in, divided level out
  input wire logic lvl_in,
  output logic lvl_out
);

  logic prev_r;
  logic [CNT_W-1:0] cnt_r;
  wire rise = lvl_in & ~prev_r;

  function automatic logic pick(input logic [1:0] s, input logic l,
                                input logic [CNT_W-1:0] c);
    logic r;
    r = l;
    if (s != 2'h0)
      r = c[s - 2'h1];
    return r;
  endfunction : pick

  // A counter bit is a symmetric divide by a power of two
  assign lvl_out = pick(sel, lvl_in, cnt_r);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      prev_r <= lvl_in;
      if (clear)
        cnt_r <= '0;
      else if (rise)
        cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : ripple_prescaler

// ==== verification/count_source_model.sv ====
// Far-side model: external count clock or watch crystal source
`timescale 1ns/100ps
module count_source_model (
  // Clock
  input wire logic clk,
  // Burst request
  input wire logic go,
  input wire logic use_osc,
  input wire logic [7:0] n,
  input wire logic [3:0] half,
  // Pins and status
  output logic ext_count_clock_pin,
  output logic osc_input_pin,
  output logic busy
);
  logic [7:0] left = 8'h00;
  logic [3:0] t = 4'h0;
  logic lvl = 1'b0;
  // Unselected pin and idle clock stand low so no stray edge is counted
  assign ext_count_clock_pin = !use_osc && lvl;
  assign osc_input_pin = use_osc && lvl;
  assign busy = left != 8'h00 || lvl;
  ////////////////////////////////////////
  // High and low each last half clocks; keep half >= 2 for the sampler
  always @(posedge clk)
    if (go && !busy)
    begin
      left <= n;
      t <= 4'h0;
    end
    else if (busy)
    begin
      t <= (t == half - 4'h1) ? 4'h0 : t + 4'h1;
      if (t == half - 4'h1)
      begin
        lvl <= !lvl && left != 8'h00;
        if (!lvl)
          left <= left - 8'h01;
      end
    end
endmodule : count_source_model

// ==== verification/timer_one_properties.sv ====
// Port-level timing relations of the 16-bit timer/counter
`timescale 1ns/100ps
module timer_one_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Inputs
  input wire timer_one_pkg::bus_req_t bus_req,
  input wire logic [1:0] port_direction,
  input wire logic sleep,
  input wire logic compare_reset,
  // Outputs
  input wire logic [7:0] rd_data_r,
  input wire logic [15:0] count_out_r,
  input wire logic irq_r,
  input wire logic wake_r,
  input wire logic osc_amp_en_r,
  input wire logic [1:0] osc_pin_oe_r
);
  import timer_one_pkg::*;
  logic [7:0] ctl_sh;
  logic ien_sh;
  logic [3:0] age;
  wire sh_wr = bus_req.wr && bus_req.addr == 8'h10;
  wire cnt_wr = bus_req.wr && bus_req.addr[7:1] == 7'h07;
  wire rd_ctl = bus_req.rd && bus_req.addr == 8'h10;
  wire xtal = ctl_sh[3];
  wire unsync = ctl_sh[1] && ctl_sh[2];
  // Pending writes and sync delays have drained once age saturates
  wire quiet = age == 4'hf;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      ctl_sh <= 8'h00;
      ien_sh <= 1'b0;
      age <= 4'h0;
    end
    else
    begin
      if (sh_wr)
        ctl_sh <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == 8'h8c)
        ien_sh <= bus_req.wdata[0];
      if (cnt_wr || sh_wr || compare_reset)
        age <= 4'h0;
      else if (!quiet)
        age <= age + 4'h1;
    end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_CTRL_RD: assert property ($past(rd_ctl) |->
    rd_data_r == ($past(ctl_sh) & 8'h3f)) else $error("control readback");
  AST_OE_FORCED: assert property (osc_amp_en_r |->
    osc_pin_oe_r == 2'h0) else $error("crystal pins driven");
  AST_OE_DIR: assert property (!osc_amp_en_r && $past(resetn) |->
    osc_pin_oe_r == ~$past(port_direction)) else $error("pin direction");
  AST_AMP: assert property (osc_amp_en_r == $past(xtal))
    else $error("amplifier enable");
  AST_IRQ_MASK: assert property (irq_r |-> $past(ien_sh))
    else $error("masked interrupt");
  AST_WAKE: assert property (wake_r |-> $past(sleep) && $past(unsync))
    else $error("wake outside unsync sleep");
  AST_HOLD_OFF: assert property (quiet && !ctl_sh[0] |->
    $stable(count_out_r)) else $error("count moved while off");
  AST_STEP: assert property (quiet && $changed(count_out_r) |->
    count_out_r == $past(count_out_r) + 16'h1) else $error("count step");
  AST_CRESET: assert property (compare_reset && quiet |->
    ##[1:2] count_out_r == 16'h0000) else $error("compare reset");
  cover property (irq_r);
  cover property (wake_r);
  cover property (compare_reset && quiet);
endmodule : timer_one_properties

bind timer_one timer_one_properties timer_one_properties_inst (
  .clk(clk), .resetn(resetn), .bus_req(bus_req),
  .port_direction(port_direction), .sleep(sleep),
  .compare_reset(compare_reset), .rd_data_r(rd_data_r),
  .count_out_r(count_out_r), .irq_r(irq_r), .wake_r(wake_r),
  .osc_amp_en_r(osc_amp_en_r), .osc_pin_oe_r(osc_pin_oe_r));

// ==== verification/tb_top.sv ====
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/100ps
module tb_top;
  import timer_one_pkg::*;
  logic clk, resetn, sleep, compare_reset, go, use_osc;
  logic ext_pin, osc_pin, busy, irq_r, wake_r, amp, tbok;
  bus_req_t bus_req;
  logic [7:0] rd_data_r, n, d, v;
  logic [1:0] port_direction, osc_pin_oe_r;
  logic [15:0] count_out_r, c0;
  logic [7:0] tab [6] = '{8'h03, 8'h0b, 8'h13, 8'h07, 8'h03, 8'h07};
  int seed = 32'hfd8d;
  int mismatches = 0;
  int checks_done = 0;
  timer_one timer_one_inst (.clk(clk), .resetn(resetn),
    .bus_req(bus_req), .rd_data_r(rd_data_r),
    .ext_count_clock_pin(ext_pin), .osc_input_pin(osc_pin),
    .port_direction(port_direction), .sleep(sleep),
    .compare_reset(compare_reset), .count_out_r(count_out_r),
    .timebase_ok_r(tbok), .irq_r(irq_r), .wake_r(wake_r),
    .osc_amp_en_r(amp), .osc_pin_oe_r(osc_pin_oe_r));
  count_source_model count_source_model_inst (.clk(clk), .go(go),
    .use_osc(use_osc), .n(n), .half(4'h3),
    .ext_count_clock_pin(ext_pin), .osc_input_pin(osc_pin), .busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e)
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    if (g !== e)
      mismatches++;
  endtask : chk
  task automatic wr(input logic [7:0] a, x);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, a, x};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus_req <= '0;
    // Read data stand in the cycle after the strobe; taken at its end
    @(posedge clk);
    x = rd_data_r;
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Sleep gates only the synchronised path; prescale divides the pulses
  function automatic logic [15:0] expc(input logic [7:0] c, p, logic s);
    if (s && !c[2])
      return 16'h0000;
    return {8'h00, p >> c[5:4]};
  endfunction : expc
  // Burst of pulses from the far side; count starts just below wrap
  task automatic burst(input logic [7:0] c, input logic s);
    int k;
    wr(8'h10, c);
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hfc);
    sleep <= s;
    use_osc <= c[3];
    n <= 8'h04 + (8'($random(seed)) & 8'h0e);
    repeat (8) @(posedge clk);
    c0 = count_out_r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 300 && busy; k++)
      @(posedge clk);
    if (busy)
      mismatches++;
    if (busy)
      give_verdict();
    repeat (12) @(posedge clk);
    chk(count_out_r - c0, expc(c, n, s));
    chk(tbok, !(c[1] && c[2]));
  endtask : burst
  ////////////////////////////////////////
  initial
  begin
    {resetn, sleep, compare_reset, go, use_osc} = 5'h00;
    bus_req = '0;
    n = 8'h04;
    port_direction = 2'h3;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h10, v);
    chk(v, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, v);
    chk(v, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 8'hff : 8'($random(seed));
      port_direction <= d[7:6];
      wr(8'h10, d);
      rd(8'h10, v);
      chk(v, d & 8'h3f);
      chk(amp, d[3]);
      chk(osc_pin_oe_r, d[3] ? 2'h0 : 2'(~d[7:6]));
    end
    wr(8'h0f, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      d = 8'($random(seed));
      wr(8'h10, {2'h0, 2'(p), 1'b0, d[2], 2'h1});
      wr(8'h0e, 8'h00);
      repeat (8) @(posedge clk);
      c0 = count_out_r;
      repeat (20 << p) @(posedge clk);
      chk(count_out_r - c0, 16'h0005);
    end
    wr(8'h10, 8'h01);
    wr(8'h0c, 8'h00);
    wr(8'h8c, 8'h01);
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hfd);
    repeat (30) @(posedge clk);
    rd(8'h0c, v);
    chk(v, 8'h01);
    chk(irq_r, 1'b1);
    rd(8'h0f, v);
    chk(v, 8'h00);
    wr(8'h8c, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq_r, 1'b0);
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h00);
    repeat (8) @(posedge clk);
    c0 = count_out_r;
    repeat (40) @(posedge clk);
    chk(count_out_r, c0);
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hf0);
    repeat (16) @(posedge clk);
    compare_reset <= 1'b1;
    @(posedge clk);
    compare_reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk(count_out_r, 16'h0000);
    rd(8'h0c, v);
    chk(v, 8'h00);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, 8'h0e, 8'h5a};
    compare_reset <= 1'b1;
    @(posedge clk);
    bus_req <= '0;
    compare_reset <= 1'b0;
    repeat (6) @(posedge clk);
    chk(count_out_r, 16'h005a);
    // Mid-run reset: control returns to zero, the count survives
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h0e, v);
    chk(v, 8'h5a);
    rd(8'h10, v);
    chk(v, 8'h00);
    wr(8'h8c, 8'h01);
    for (int i = 0; i < 6; i++)
      burst(tab[i], i > 3);
    chk(wake_r, 1'b1);
    give_verdict();
  end
endmodule : tb_top
